/* File: verilog/sfc_defines.svh */
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// ==========================================================
// Opcodes sent to the flash
// ==========================================================
`define SFC_OP_WRITE_UNLOCK 8'h06
`define SFC_OP_WRITE_LOCK 8'h04
`define SFC_OP_READ_IDENT 8'h9F
`define SFC_OP_STATUS_READ 8'h05
`define SFC_OP_STATUS_WRITE 8'h01
`define SFC_OP_READ 8'h03
`define SFC_OP_QUICK_READ 8'h0B
`define SFC_OP_PAGE_WRITE 8'h02
`define SFC_OP_ZONE_WIPE 8'hD8
`define SFC_OP_WHOLE_WIPE 8'hC7
`define SFC_OP_DEEP_PD 8'hB9
`define SFC_OP_WAKE_SIG 8'hAB

// ==========================================================
// Transaction shapes and status byte layout
// ==========================================================
`define SFC_HDR_PLAIN 3'h1
`define SFC_HDR_ADDR 3'h4
`define SFC_HDR_QUICK 3'h5
`define SFC_ADDR_BYTES 2'h3
`define SFC_DUMMY_BYTE 8'h00
`define SFC_LEN_ONE 9'h001
`define SFC_LEN_ID_MAX 9'h014
`define SFC_LEN_PAGE_MAX 9'h100
`define SFC_LEN_INF 9'h1FF
`define SFC_ST_BUSY_BIT 0
`define SFC_ST_WEL_BIT 1

// ==========================================================
// Timing counts in clk_i cycles
// ==========================================================
`define SFC_SCK_HALF 4
`define SFC_GAP_CYC 4

`endif

/* File: verilog/sfc_pkg.sv */
package sfc_pkg;

    // ======================================================
    // Controller types
    // ======================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SHIFT,
        ST_END,
        ST_DONE
    } sfc_state_t;

    typedef enum logic [1:0] {
        TK_UNLOCK,
        TK_MAIN,
        TK_POLL
    } sfc_kind_t;

    typedef struct packed {
        logic ok;
        logic [2:0] hdr_n;
        logic [1:0] addr_n;
        logic rd;
        logic modify;
        logic [8:0] len_min;
        logic [8:0] len_max;
    } sfc_shape_t;

    typedef struct packed {
        sfc_state_t st;
        sfc_kind_t kind;
        logic [7:0] op;
        logic [23:0] addr;
        logic [2:0] hdr_n;
        logic [1:0] addr_n;
        logic rd;
        logic modify;
        logic poll;
        logic [8:0] len;
        logic [9:0] idx;
        logic [7:0] sh;
        logic [7:0] rx;
        logic [2:0] bit_cnt;
        logic [3:0] gap;
        logic pd;
        logic unlocked;
        logic cs_n;
        logic sck;
        logic mosi;
        logic wr_ready;
        logic rd_valid;
        logic [7:0] rd_data;
        logic [7:0] status;
        logic done;
        logic err;
        logic busy;
    } sfc_regs_t;

endpackage : sfc_pkg

/* File: verilog/sfc_sync.sv */
`timescale 1ns/100ps

module sfc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    if (W < 1) begin : g_bad_width
        $error("sfc_sync needs W of at least one");
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : sfc_sync

/* File: verilog/sfc_clkdiv.sv */
`timescale 1ns/100ps

module sfc_clkdiv #(
    parameter int HALF = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Run request and half-period tick
    input wire logic run_i,
    output logic tick_o
);
    localparam int W = (HALF < 2) ? 1 : $clog2(HALF);
    logic [W-1:0] cnt_q;

    if (HALF < 2) begin : g_bad_half
        $error("sfc_clkdiv needs HALF of at least two");
    end

    // The count restarts whenever the engine pauses, so every phase
    // lasts at least HALF cycles.
    assign tick_o = run_i && (cnt_q == W'(HALF - 1));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (!run_i || tick_o) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule : sfc_clkdiv

/* File: verilog/sfc_host.sv */
`timescale 1ns/100ps
`include "sfc_defines.svh"

module sfc_host #(
    parameter int SCK_HALF = `SFC_SCK_HALF,
    parameter int GAP_CYC = `SFC_GAP_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Command request
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_op_i,
    input wire logic [23:0] cmd_addr_i,
    input wire logic [8:0] cmd_len_i,
    input wire logic poll_en_i,
    // Write data stream
    input wire logic [7:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    // Read data stream
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // Command status
    output logic busy_o,
    output logic done_o,
    output logic err_o,
    output logic [7:0] status_o,
    output logic power_down_o,
    // Serial link
    output logic spi_cs_n_o,
    output logic spi_sck_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i
);
    import sfc_pkg::*;

    localparam int GAP_LIM = 24;
    localparam sfc_regs_t REGS_RST = '{
        st: ST_IDLE,
        kind: TK_UNLOCK,
        cs_n: 1'b1,
        default: '0
    };

    if (SCK_HALF < 3 || GAP_CYC < 1 || GAP_CYC > 15) begin : g_bad_par
        $error("sfc_host needs SCK_HALF >= 3 and GAP_CYC in 1..15");
    end

    // ======================================================
    // Command decoding
    // ======================================================
    function automatic sfc_shape_t decode(input logic [7:0] op,
                                          input logic [8:0] len);
        sfc_shape_t s;
        s = '0;
        s.hdr_n = `SFC_HDR_PLAIN;
        case (op)
            `SFC_OP_WRITE_UNLOCK, `SFC_OP_WRITE_LOCK, `SFC_OP_DEEP_PD: begin
                s.ok = 1'b1;
            end
            `SFC_OP_WHOLE_WIPE: begin
                s.ok = 1'b1;
                s.modify = 1'b1;
            end
            `SFC_OP_ZONE_WIPE: begin
                s.ok = 1'b1;
                s.modify = 1'b1;
                s.hdr_n = `SFC_HDR_ADDR;
                s.addr_n = `SFC_ADDR_BYTES;
            end
            `SFC_OP_READ_IDENT: begin
                s.ok = 1'b1;
                s.rd = 1'b1;
                s.len_min = `SFC_LEN_ONE;
                s.len_max = `SFC_LEN_ID_MAX;
            end
            `SFC_OP_STATUS_READ: begin
                s.ok = 1'b1;
                s.rd = 1'b1;
                s.len_min = `SFC_LEN_ONE;
                s.len_max = `SFC_LEN_INF;
            end
            `SFC_OP_STATUS_WRITE: begin
                s.ok = 1'b1;
                s.modify = 1'b1;
                s.len_min = `SFC_LEN_ONE;
                s.len_max = `SFC_LEN_ONE;
            end
            `SFC_OP_READ, `SFC_OP_QUICK_READ: begin
                s.ok = 1'b1;
                s.rd = 1'b1;
                s.hdr_n = (op == `SFC_OP_READ) ? `SFC_HDR_ADDR : `SFC_HDR_QUICK;
                s.addr_n = `SFC_ADDR_BYTES;
                s.len_min = `SFC_LEN_ONE;
                s.len_max = `SFC_LEN_INF;
            end
            `SFC_OP_PAGE_WRITE: begin
                s.ok = 1'b1;
                s.modify = 1'b1;
                s.hdr_n = `SFC_HDR_ADDR;
                s.addr_n = `SFC_ADDR_BYTES;
                s.len_min = `SFC_LEN_ONE;
                s.len_max = `SFC_LEN_PAGE_MAX;
            end
            `SFC_OP_WAKE_SIG: begin
                // A plain wake has no dummies; a signature read has three.
                s.ok = 1'b1;
                s.rd = 1'b1;
                s.hdr_n = (len == 9'h000) ? `SFC_HDR_PLAIN : `SFC_HDR_ADDR;
                s.len_max = `SFC_LEN_INF;
            end
            default: begin
                s.ok = 1'b0;
            end
        endcase
        s.ok = s.ok && (len >= s.len_min) && (len <= s.len_max);
        return s;
    endfunction : decode

    // ======================================================
    // State and helpers
    // ======================================================
    sfc_regs_t q;
    sfc_regs_t d;
    sfc_shape_t shape;
    logic tick;
    logic miso_s;
    logic [7:0] cur_op;
    logic [2:0] cur_hdr;
    logic [9:0] cur_total;
    logic [7:0] rxn;
    logic [7:0] next_byte;
    logic in_hdr;

    sfc_sync #(.W(1)) u_miso_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(spi_miso_i),
        .sync_o(miso_s)
    );

    sfc_clkdiv #(.HALF(SCK_HALF)) u_sck_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(q.st == ST_SHIFT),
        .tick_o(tick)
    );

    assign shape = decode(cmd_op_i, cmd_len_i);
    assign cur_op = (q.kind == TK_UNLOCK) ? `SFC_OP_WRITE_UNLOCK :
                    (q.kind == TK_POLL) ? `SFC_OP_STATUS_READ : q.op;
    assign cur_hdr = (q.kind == TK_MAIN) ? q.hdr_n : `SFC_HDR_PLAIN;
    assign cur_total = (q.kind == TK_UNLOCK) ? 10'h001 :
                       ({7'h00, q.hdr_n} + {1'b0, q.len});
    assign in_hdr = q.idx < {7'h00, cur_hdr};
    // Sampling at the end of the high phase lets the synchroniser
    // delay land inside the window where the flash holds its bit.
    assign rxn = {q.rx[6:0], miso_s};

    always_comb begin
        next_byte = `SFC_DUMMY_BYTE;
        if (q.idx == 10'h000) begin
            next_byte = cur_op;
        end else if (q.kind == TK_MAIN && q.idx <= {8'h00, q.addr_n}) begin
            unique case (q.idx[1:0])
                2'h1: next_byte = q.addr[23:16];
                2'h2: next_byte = q.addr[15:8];
                default: next_byte = q.addr[7:0];
            endcase
        end
    end

    // ======================================================
    // Sequencer
    // ======================================================
    always_comb begin
        d = q;
        d.rd_valid = 1'b0;
        d.done = 1'b0;
        d.err = 1'b0;
        unique case (q.st)
            ST_IDLE: begin
                if (cmd_valid_i) begin
                    if (!shape.ok || (shape.modify && q.pd)) begin
                        d.err = 1'b1;
                    end else begin
                        d.op = cmd_op_i;
                        d.addr = cmd_addr_i;
                        d.hdr_n = shape.hdr_n;
                        d.addr_n = shape.addr_n;
                        d.rd = shape.rd;
                        d.modify = shape.modify;
                        d.poll = poll_en_i;
                        d.len = cmd_len_i;
                        d.idx = 10'h000;
                        d.busy = 1'b1;
                        d.kind = shape.modify ? TK_UNLOCK : TK_MAIN;
                        d.st = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                if (q.kind != TK_POLL && q.idx == cur_total) begin
                    d.cs_n = 1'b1;
                    d.gap = 4'h0;
                    d.st = ST_END;
                end else if (in_hdr || q.rd || q.kind == TK_POLL ||
                             (q.wr_ready && wr_valid_i)) begin
                    d.sh = (in_hdr || q.rd || q.kind == TK_POLL) ?
                           next_byte : wr_data_i;
                    d.mosi = d.sh[7];
                    d.wr_ready = 1'b0;
                    d.cs_n = 1'b0;
                    d.bit_cnt = 3'h0;
                    d.st = ST_SHIFT;
                    if (q.kind == TK_MAIN && q.idx == 10'h000) begin
                        d.unlocked = 1'b0;
                    end
                end else begin
                    // Holding the clock low stalls the flash without harm.
                    d.wr_ready = 1'b1;
                end
            end
            ST_SHIFT: begin
                if (tick && !q.sck) begin
                    d.sck = 1'b1;
                end else if (tick) begin
                    d.sck = 1'b0;
                    d.rx = rxn;
                    d.sh = {q.sh[6:0], 1'b0};
                    d.mosi = q.sh[6];
                    d.bit_cnt = q.bit_cnt + 3'h1;
                    if (q.bit_cnt == 3'h7) begin
                        d.st = ST_LOAD;
                        d.idx = (q.kind == TK_POLL && q.idx != 10'h000) ?
                                q.idx : q.idx + 10'h001;
                        if (!in_hdr && q.kind == TK_POLL) begin
                            d.status = rxn;
                            if (!rxn[`SFC_ST_BUSY_BIT]) begin
                                d.cs_n = 1'b1;
                                d.gap = 4'h0;
                                d.st = ST_END;
                            end
                        end else if (!in_hdr && q.rd) begin
                            d.rd_valid = 1'b1;
                            d.rd_data = rxn;
                            if (q.op == `SFC_OP_STATUS_READ) begin
                                d.status = rxn;
                            end
                        end
                    end
                end
            end
            ST_END: begin
                d.sck = 1'b0;
                d.cs_n = 1'b1;
                d.gap = q.gap + 4'h1;
                if (q.gap == 4'(GAP_CYC - 1)) begin
                    d.idx = 10'h000;
                    d.st = ST_DONE;
                    if (q.kind == TK_UNLOCK) begin
                        d.kind = TK_MAIN;
                        d.unlocked = 1'b1;
                        d.st = ST_LOAD;
                    end else if (q.kind == TK_MAIN && q.modify && q.poll) begin
                        d.kind = TK_POLL;
                        d.st = ST_LOAD;
                    end
                end
            end
            ST_DONE: begin
                d.done = 1'b1;
                d.busy = 1'b0;
                if (q.op == `SFC_OP_DEEP_PD) begin
                    d.pd = 1'b1;
                end else if (q.op == `SFC_OP_WAKE_SIG) begin
                    d.pd = 1'b0;
                end
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    assign wr_ready_o = q.wr_ready;
    assign rd_data_o = q.rd_data;
    assign rd_valid_o = q.rd_valid;
    assign busy_o = q.busy;
    assign done_o = q.done;
    assign err_o = q.err;
    assign status_o = q.status;
    assign power_down_o = q.pd;
    assign spi_cs_n_o = q.cs_n;
    assign spi_sck_o = q.sck;
    assign spi_mosi_o = q.mosi;

    // ======================================================
    // Checks
    // ======================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_unlock_end;
        q.kind == TK_UNLOCK && q.st == ST_END && q.gap == 4'(GAP_CYC - 1);
    endsequence

    sequence s_main_start;
        q.kind == TK_MAIN && q.st == ST_LOAD ##1 !spi_cs_n_o;
    endsequence

    sequence s_op_start;
        q.st == ST_SHIFT && $past(q.st) == ST_LOAD && q.idx == 10'h000;
    endsequence

    msb_first_a: assert property (
        s_op_start |-> spi_mosi_o == cur_op[7])
        else $error("opcode did not start with its top bit");
    mosi_stable_a: assert property (
        spi_sck_o && $past(spi_sck_o) |-> $stable(spi_mosi_o))
        else $error("data moved while the clock was high");
    opcode_first_a: assert property (
        $fell(spi_cs_n_o) |-> q.idx == 10'h000 && q.sh == cur_op)
        else $error("selection did not start with the opcode");
    byte_boundary_a: assert property (
        $rose(spi_cs_n_o) |-> q.bit_cnt == 3'h0 && !spi_sck_o)
        else $error("deselection off a byte boundary");
    unlock_before_a: assert property (
        $fell(spi_cs_n_o) && q.kind == TK_MAIN && q.modify
        |-> $past(q.unlocked))
        else $error("modifying command sent without a write unlock");
    unlock_then_main_a: assert property (
        s_unlock_end |=> s_main_start ##[1:GAP_LIM] q.st == ST_SHIFT)
        else $error("write unlock not followed by the command");
    unlock_len_a: assert property (
        q.kind == TK_UNLOCK && q.st != ST_IDLE |-> q.idx <= 10'h001)
        else $error("write unlock longer than one byte");
    pd_guard_a: assert property (
        $fell(spi_cs_n_o) && q.kind == TK_MAIN && q.modify |-> !q.pd)
        else $error("modifying command sent in deep power-down");
    poll_clear_a: assert property (
        $rose(spi_cs_n_o) && q.kind == TK_POLL
        |-> !status_o[`SFC_ST_BUSY_BIT])
        else $error("polling ended while busy");
    rd_byte_a: assert property (
        rd_valid_o |-> $fell(spi_sck_o) && $past(q.bit_cnt) == 3'h7)
        else $error("read byte delivered off a byte end");
    ident_len_a: assert property (
        q.st == ST_SHIFT && q.kind == TK_MAIN &&
        q.op == `SFC_OP_READ_IDENT |-> q.idx <= 10'h014)
        else $error("identity read beyond twenty bytes");
endmodule : sfc_host

/* File: testbench/sfc_flash_model.sv */
`timescale 1ns/100ps

// ==========================================================
// Behavioural flash at the far end of the serial link
// ==========================================================
module sfc_flash_model #(
    parameter int BUSY_CLKS = 40,
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value.
    parameter logic [7:0] DEV_HI = 8'hC3, // Arbitrary value.
    parameter logic [7:0] DEV_LO = 8'h3C, // Arbitrary value.
    parameter logic [7:0] SIG = 8'h6D // Arbitrary value.
) (
    // Serial link
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o
);
    logic [7:0] st = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] out = 8'h00;
    logic [7:0] rx_q[$];
    logic [7:0] mod_q[$];
    logic pd = 1'b0;
    int n = 0;
    int hdr = 1;
    int cnt = 0;
    int n_exec = 0;

    initial miso_o = 1'b0;

    function automatic logic [7:0] val(input int k);
        case (rx_q[0])
            8'h05: return st;
            8'h9F: begin
                if (st[0]) return 8'hFF;
                return k == 0 ? MAKER : k == 1 ? DEV_HI : k == 2 ? DEV_LO :
                    k == 3 ? 8'h10 : 8'h00;
            end
            8'hAB: return SIG;
            default: return 8'hA5 ^ 8'(k);
        endcase
    endfunction : val

    always @(negedge cs_n_i) begin
        n = 0;
        rx_q = {};
    end

    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            sh = {sh[6:0], mosi_i};
            n++;
            if (n % 8 == 0) begin
                rx_q.push_back(sh);
                hdr = rx_q[0] == 8'h03 || rx_q[0] == 8'hAB ? 4 :
                    rx_q[0] == 8'h0B ? 5 : 1;
                if (n / 8 >= hdr) out = val(n / 8 - hdr);
            end
            if (st[0]) begin
                cnt--;
                if (cnt == 0) st = 8'h00;
            end
        end
    end

    always @(negedge sck_i) begin
        if (!cs_n_i) begin
            miso_o = out[7];
            out = {out[6:0], 1'b0};
        end
    end

    // A released data line shows the inverse so stale bits never pass.
    always @(posedge cs_n_i) begin
        miso_o = ~miso_o;
        if (n % 8 == 0 && rx_q.size() > 0) begin
            case (rx_q[0])
                8'h06: if (!pd) st[1] = 1'b1;
                8'h04: st[1] = 1'b0;
                8'hB9: pd = 1'b1;
                8'hAB: pd = 1'b0;
                8'h01, 8'h02, 8'hD8, 8'hC7: begin
                    if (st[1] && !st[0] && !pd) begin
                        st[0] = 1'b1;
                        cnt = BUSY_CLKS;
                        n_exec++;
                        mod_q = rx_q;
                    end
                end
                default: ;
            endcase
        end
    end
endmodule : sfc_flash_model

/* File: testbench/testbench.sv */
`timescale 1ns/100ps

module testbench;
    logic clk_i, rst_i, cmd_valid_i, poll_en_i, wr_valid_i, spi_miso_i;
    logic [7:0] cmd_op_i, wr_data_i, rd_data_o, status_o;
    logic [23:0] cmd_addr_i;
    logic [8:0] cmd_len_i;
    logic wr_ready_o, rd_valid_o, busy_o, done_o, err_o, power_down_o;
    logic spi_cs_n_o, spi_sck_o, spi_mosi_o;
    logic [7:0] exp_q[$];
    logic [7:0] wr_q[$];
    logic [7:0] op_tab[4] = '{8'h01, 8'h02, 8'hD8, 8'hC7};
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'h91ab;

    sfc_host #(.SCK_HALF(4), .GAP_CYC(1)) uut (.clk_i, .rst_i, .cmd_valid_i,
        .cmd_op_i, .cmd_addr_i, .cmd_len_i, .poll_en_i, .wr_data_i,
        .wr_valid_i, .wr_ready_o, .rd_data_o, .rd_valid_o, .busy_o, .done_o,
        .err_o, .status_o, .power_down_o, .spi_cs_n_o, .spi_sck_o,
        .spi_mosi_o, .spi_miso_i);
    sfc_flash_model flash (.cs_n_i(spi_cs_n_o), .sck_i(spi_sck_o),
        .mosi_i(spi_mosi_o), .miso_o(spi_miso_i));

    // ======================================================
    // Shared tasks
    // ======================================================
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                       input int len, input logic pl, output logic e);
        logic f;
        @(negedge clk_i);
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_len_i = 9'(len);
        poll_en_i = pl;
        cmd_valid_i = 1'b1;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        // A refusal pulses for one cycle only, so look before waiting.
        e = err_o === 1'b1;
        f = e;
        for (int i = 0; i < 4000 && !f; i++) begin
            @(negedge clk_i);
            e = err_o === 1'b1;
            f = e || done_o === 1'b1;
        end
        chk(f, 1'b1);
    endtask : cmd

    // ======================================================
    // Clock, write feeder, read monitor and timeout
    // ======================================================
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(negedge clk_i) begin
        if (wr_valid_i && wr_ready_o === 1'b0) void'(wr_q.pop_front());
        wr_valid_i = wr_ready_o === 1'b1 && wr_q.size() > 0;
        wr_data_i = wr_q.size() > 0 ? wr_q[0] : 8'h00;
        if (rd_valid_o === 1'b1) begin
            chk(rd_data_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            stop_test();
        end
    end

    // ======================================================
    // Main sequence
    // ======================================================
    initial begin
        logic e;
        logic [23:0] a;
        logic [7:0] wb[$];
        int len, hd;
        {cmd_valid_i, poll_en_i, wr_valid_i, wr_data_i} = '0;
        {cmd_op_i, cmd_addr_i, cmd_len_i} = '0;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        chk({spi_cs_n_o, spi_sck_o, busy_o}, 3'b100);
        cmd(8'h06, 0, 0, 0, e);
        chk(24'(flash.n), 8);
        chk(flash.rx_q[0], 8'h06);
        exp_q.push_back(8'h02);
        cmd(8'h05, 0, 1, 0, e);
        cmd(8'h04, 0, 0, 0, e);
        exp_q.push_back(8'h00);
        cmd(8'h05, 0, 1, 0, e);
        for (int i = 0; i < 20; i++) begin
            exp_q.push_back(i == 0 ? flash.MAKER : i == 1 ? flash.DEV_HI :
                i == 2 ? flash.DEV_LO : i == 3 ? 8'h10 : 8'h00);
        end
        cmd(8'h9F, 0, 20, 0, e);
        for (int j = 0; j < 2; j++) begin
            a = 24'($random(seed));
            for (int i = 0; i < 3; i++) exp_q.push_back(8'hA5 ^ 8'(i));
            cmd(j ? 8'h0B : 8'h03, a, 3, 0, e);
            chk({flash.rx_q[1], flash.rx_q[2], flash.rx_q[3]}, a);
            chk(24'(flash.rx_q.size()), 7 + j);
        end
        foreach (op_tab[j]) begin
            a = 24'($random(seed));
            len = j == 0 ? 1 : j == 1 ? 2 : 0;
            hd = j == 1 || j == 2 ? 4 : 1;
            for (int i = 0; i < len; i++) wr_q.push_back(8'($random(seed)));
            wb = wr_q;
            cmd(op_tab[j], a, len, 1, e);
            chk(24'(flash.n_exec), j + 1);
            chk(status_o, 8'h00);
            chk(24'(flash.mod_q.size()), hd + len);
            chk(flash.mod_q[0], op_tab[j]);
            if (hd == 4) begin
                chk({flash.mod_q[1], flash.mod_q[2], flash.mod_q[3]}, a);
            end
            for (int i = 0; i < len; i++) chk(flash.mod_q[hd + i], wb[i]);
        end
        cmd(8'hB9, 0, 0, 0, e);
        chk(power_down_o, 1'b1);
        cmd(8'h02, 0, 1, 0, e);
        chk(e, 1'b1);
        exp_q.push_back(flash.SIG);
        cmd(8'hAB, 0, 1, 0, e);
        chk({power_down_o, 8'(flash.rx_q.size())}, 9'h005);
        for (int i = 0; i < 3; i++) begin
            cmd(i == 0 ? 8'h77 : i == 1 ? 8'h9F : 8'h06, 0, i == 1 ? 21 : i,
                0, e);
            chk(e, 1'b1);
        end
        chk(24'(exp_q.size()), 0);
        stop_test();
    end
endmodule : testbench
